// file: rtl/fbo_ctrl.sv
// module: host-side controller driving the flash bus-operation pins
`timescale 1ns/10ps
module fbo_ctrl
(
   input  wire logic                            clk_in,
   input  wire logic                            rst_n_in,
   input  wire logic                            req_valid_in,
   input  wire fbo_pkg::fbo_req_t               req_in,
   output logic                                 req_ready_out,
   output logic                                 rdata_valid_out,
   output logic [fbo_pkg::DATA_W-1:0]           rdata_out,
   input  wire logic [fbo_pkg::DATA_W-1:0]      dq_in,
   output logic                                 chip_select_n_out,
   output logic                                 output_gate_n_out,
   output logic                                 write_strobe_n_out,
   output logic                                 reset_n_out,
   output logic                                 elevated_voltage_out,
   output logic                                 width_select_n_out,
   output logic [fbo_pkg::ADDR_W-1:0]           addr_out,
   output logic [fbo_pkg::DATA_W-1:0]           dq_out,
   output logic [fbo_pkg::DATA_W-1:0]           dq_oe_n_out
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed
   {
      fbo_pkg::fbo_state_t           st;
      fbo_pkg::fbo_req_t             req;
      fbo_pkg::fbo_pins_t            pins;
      logic                          ready;
      logic                          rvalid;
      logic [fbo_pkg::DATA_W-1:0]    rdata;
   } fbo_ctrl_t;

   fbo_ctrl_t                       s_r;
   fbo_ctrl_t                       s_nxt;
   logic                            tmr_load;
   logic [fbo_pkg::CNT_W-1:0]       tmr_cnt;
   logic                            tmr_done;

   // ************************************************************
   // phase timer
   // ************************************************************
   fbo_timer u_tmr
   (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .load_in  (tmr_load),
      .count_in (tmr_cnt),
      .done_out (tmr_done)
   );

   // idle pin levels: deselected, gates high, data floated
   function automatic fbo_pkg::fbo_pins_t idle_pins(input logic bm);
      fbo_pkg::fbo_pins_t p;
      p                  = '0;
      p.chip_select_n    = 1'b1;
      p.output_gate_n    = 1'b1;
      p.write_strobe_n   = 1'b1;
      p.reset_n          = 1'b1;
      p.width_select_n   = ~bm;
      p.dq_oe_n          = 16'hFFFF;
      return p;
   endfunction

   // ************************************************************
   // sequencer: setup, strobe pulse, hold for every bus cycle except reset, which has a low pulse and recovery
   // ************************************************************
   always_comb
   begin
      s_nxt    = s_r;
      tmr_load = 1'b0;
      tmr_cnt  = '0;
      s_nxt.rvalid = 1'b0;
      unique case (s_r.st)
         fbo_pkg::FBO_ST_IDLE:
         begin
            s_nxt.ready = 1'b1;
            if (req_valid_in && s_r.ready)
            begin
               s_nxt.req   = req_in;
               s_nxt.ready = 1'b0;
               s_nxt.pins  = idle_pins(req_in.byte_mode);
               // width select fixes word or byte mode for reads and program data
               s_nxt.pins.addr = req_in.addr;
               if (req_in.op == fbo_pkg::FBO_OP_RESET)
               begin
                  // reset low aborts and returns the device to array read
                  s_nxt.pins.reset_n = 1'b0;
                  s_nxt.st = fbo_pkg::FBO_ST_RST;
                  tmr_load = 1'b1;
                  tmr_cnt  = fbo_pkg::CNT_W'(fbo_pkg::RST_CYC);
               end
               else
               begin
                  s_nxt.pins.chip_select_n = 1'b0;
                  if (req_in.op == fbo_pkg::FBO_OP_PROTECT ||
                      req_in.op == fbo_pkg::FBO_OP_UNPROTECT)
                  begin
                     // elevated voltage on reset pin, A1 high, A0 low, A6 picks the mode
                     s_nxt.pins.elevated_voltage = 1'b1;
                     s_nxt.pins.addr[fbo_pkg::ADDR_BIT_A1] = 1'b1;
                     s_nxt.pins.addr[fbo_pkg::ADDR_BIT_A0] = 1'b0;
                     s_nxt.pins.addr[fbo_pkg::ADDR_BIT_A6] =
                        (req_in.op == fbo_pkg::FBO_OP_UNPROTECT);
                  end
                  // in byte mode bit 15 carries the lowest address bit
                  if (req_in.byte_mode)
                  begin
                     s_nxt.pins.dq_out[fbo_pkg::DQ_LSB_BIT]  = req_in.addr_lsb;
                     s_nxt.pins.dq_oe_n[fbo_pkg::DQ_LSB_BIT] = 1'b0;
                  end
                  s_nxt.st = fbo_pkg::FBO_ST_SETUP;
                  tmr_load = 1'b1;
                  tmr_cnt  = fbo_pkg::CNT_W'(fbo_pkg::SETUP_CYC);
               end
            end
         end
         fbo_pkg::FBO_ST_SETUP:
         begin
            if (tmr_done)
            begin
               if (s_r.req.op == fbo_pkg::FBO_OP_READ)
               begin
                  // read: output gate low, write strobe stays high
                  s_nxt.pins.output_gate_n = 1'b0;
               end
               else
               begin
                  // write: strobe low while gate held high; one write event
                  // each write request is one bus cycle, so a bypass program costs two
                  s_nxt.pins.write_strobe_n = 1'b0;
                  s_nxt.pins.dq_out[7:0]    = s_r.req.wdata[7:0];
                  s_nxt.pins.dq_oe_n[7:0]   = 8'h00;
                  if (!s_r.req.byte_mode)
                  begin
                     s_nxt.pins.dq_out  = s_r.req.wdata;
                     s_nxt.pins.dq_oe_n = 16'h0000;
                  end
               end
               s_nxt.st = fbo_pkg::FBO_ST_PULSE;
               tmr_load = 1'b1;
               tmr_cnt  = fbo_pkg::CNT_W'(fbo_pkg::PULSE_CYC);
            end
         end
         fbo_pkg::FBO_ST_PULSE:
         begin
            if (tmr_done)
            begin
               if (s_r.req.op == fbo_pkg::FBO_OP_READ)
               begin
                  // byte mode keeps only bits 7..0; status and id also live there
                  s_nxt.rdata  = s_r.req.byte_mode ? {8'h00, dq_in[7:0]} : dq_in;
                  s_nxt.rvalid = 1'b1;
               end
               s_nxt.pins.output_gate_n  = 1'b1;
               s_nxt.pins.write_strobe_n = 1'b1;
               s_nxt.st = fbo_pkg::FBO_ST_HOLD;
               tmr_load = 1'b1;
               tmr_cnt  = fbo_pkg::CNT_W'(fbo_pkg::HOLD_CYC);
            end
         end
         fbo_pkg::FBO_ST_HOLD:
         begin
            if (tmr_done)
            begin
               s_nxt.pins = idle_pins(s_r.req.byte_mode);
               s_nxt.st   = fbo_pkg::FBO_ST_IDLE;
            end
         end
         fbo_pkg::FBO_ST_RST:
         begin
            if (tmr_done)
            begin
               s_nxt.pins.reset_n = 1'b1;
               s_nxt.st = fbo_pkg::FBO_ST_REC;
               tmr_load = 1'b1;
               tmr_cnt  = fbo_pkg::CNT_W'(fbo_pkg::REC_CYC);
            end
         end
         fbo_pkg::FBO_ST_REC:
         begin
            if (tmr_done)
            begin
               s_nxt.st = fbo_pkg::FBO_ST_IDLE;
            end
         end
         default:
         begin
            s_nxt.st = fbo_pkg::FBO_ST_IDLE;
         end
      endcase
      // a new request is only taken from idle
      if (s_nxt.st != fbo_pkg::FBO_ST_IDLE)
      begin
         s_nxt.ready = 1'b0;
      end
   end

   // register all state; reset parks the bus deselected
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         s_r                        <= '0;
         s_r.st                     <= fbo_pkg::FBO_ST_IDLE;
         s_r.pins.chip_select_n     <= 1'b1;
         s_r.pins.output_gate_n     <= 1'b1;
         s_r.pins.write_strobe_n    <= 1'b1;
         s_r.pins.reset_n           <= 1'b1;
         s_r.pins.width_select_n    <= 1'b1;
         s_r.pins.dq_oe_n           <= 16'hFFFF;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************
   // outputs, all straight from flip-flops
   // ************************************************************
   assign req_ready_out        = s_r.ready;
   assign rdata_valid_out      = s_r.rvalid;
   assign rdata_out            = s_r.rdata;
   assign chip_select_n_out    = s_r.pins.chip_select_n;
   assign output_gate_n_out    = s_r.pins.output_gate_n;
   assign write_strobe_n_out   = s_r.pins.write_strobe_n;
   assign reset_n_out          = s_r.pins.reset_n;
   assign elevated_voltage_out = s_r.pins.elevated_voltage;
   assign width_select_n_out   = s_r.pins.width_select_n;
   assign addr_out             = s_r.pins.addr;
   assign dq_out               = s_r.pins.dq_out;
   assign dq_oe_n_out          = s_r.pins.dq_oe_n;

   // ************************************************************
   // assertions
   // ************************************************************
   a_read_gate_levels: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !output_gate_n_out |-> !chip_select_n_out && write_strobe_n_out)
      else $error("read gate without select or with strobe low");
   a_write_strobe_lv: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !write_strobe_n_out |-> !chip_select_n_out && output_gate_n_out)
      else $error("write strobe with gate low or unselected");
   a_no_drive_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !output_gate_n_out |-> dq_oe_n_out[7:0] == 8'hFF)
      else $error("host drives data during read");
   a_byte_lsb_pin: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (!chip_select_n_out && !width_select_n_out) |-> !dq_oe_n_out[15]
      && dq_oe_n_out[14:8] == 7'h7F)
      else $error("byte mode pin use wrong");
   a_strobe_width: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $fell(write_strobe_n_out) |-> !write_strobe_n_out[*2] ##1 write_strobe_n_out)
      else $error("write pulse width wrong");
   a_protect_addr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      elevated_voltage_out && !write_strobe_n_out |-> addr_out[1] && !addr_out[0])
      else $error("protect address bits wrong");
   a_reset_width: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $fell(reset_n_out) |-> (!reset_n_out && chip_select_n_out)[*5] ##1 reset_n_out)
      else $error("reset pulse wrong");
   a_read_return: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $fell(output_gate_n_out) |-> ##2 rdata_valid_out)
      else $error("read data not returned");
   a_word_mode: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (!write_strobe_n_out && width_select_n_out) |-> dq_oe_n_out == 16'h0000)
      else $error("word write not driving all lines");
   c_read: cover property (@(posedge clk_in) disable iff (!rst_n_in) rdata_valid_out);
   c_write: cover property (@(posedge clk_in) disable iff (!rst_n_in) $fell(write_strobe_n_out));
   c_reset: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(reset_n_out));
   c_prot: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      elevated_voltage_out && !write_strobe_n_out);
endmodule // fbo_ctrl

// file: pkg/fbo_pkg.sv
// package: pin levels, operation codes and timing counts for the flash bus-operation controller
// What this block does
// - host reads with chip select and output gate low, write strobe high
// - host writes commands with write strobe and chip select low, output gate high
// - address spans bits 19..0 in word mode, 19..-1 in byte mode
// - unlock-bypass program needs two host writes instead of four
// - protect: reset at elevated voltage, select and strobe low, addr 6 low, 1 high, 0 low
// - unprotect: same levels but address bit 6 high
package fbo_pkg;
   // ************************************************************
   // operation codes and states
   // ************************************************************
   typedef enum logic [2:0]
   {
      FBO_OP_READ      = 3'b000,
      FBO_OP_WRITE     = 3'b001,
      FBO_OP_RESET     = 3'b010,
      FBO_OP_PROTECT   = 3'b011,
      FBO_OP_UNPROTECT = 3'b100
   } fbo_op_t;

   typedef enum logic [2:0]
   {
      FBO_ST_IDLE  = 3'b000,
      FBO_ST_SETUP = 3'b001,
      FBO_ST_PULSE = 3'b010,
      FBO_ST_HOLD  = 3'b011,
      FBO_ST_RST   = 3'b100,
      FBO_ST_REC   = 3'b101
   } fbo_state_t;

   // ************************************************************
   // widths and field positions
   // ************************************************************
   localparam int ADDR_W      = 20;
   localparam int DATA_W      = 16;
   localparam int ADDR_BIT_A6 = 6;
   localparam int ADDR_BIT_A1 = 1;
   localparam int ADDR_BIT_A0 = 0;
   localparam int DQ_LSB_BIT  = 15;

   // ************************************************************
   // timing: times in ns, cycles at 100 ns clock
   // ************************************************************
   localparam int CLK_NS       = 100;
   localparam int SETUP_NS     = 100;
   localparam int PULSE_NS     = 200;
   localparam int HOLD_NS      = 100;
   localparam int RST_NS       = 500;
   localparam int REC_NS       = 100;
   localparam int SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_CYC    = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC     = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int RST_CYC      = (RST_NS + CLK_NS - 1) / CLK_NS;
   localparam int REC_CYC      = (REC_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W        = 4;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed
   {
      fbo_op_t             op;
      logic                byte_mode;
      logic [ADDR_W-1:0]   addr;
      logic                addr_lsb;
      logic [DATA_W-1:0]   wdata;
   } fbo_req_t;

   typedef struct packed
   {
      logic                chip_select_n;
      logic                output_gate_n;
      logic                write_strobe_n;
      logic                reset_n;
      logic                elevated_voltage;
      logic                width_select_n;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   dq_out;
      logic [DATA_W-1:0]   dq_oe_n;
   } fbo_pins_t;
endpackage

// file: rtl/fbo_timer.sv
// module: down-counter that marks the last cycle of a bus phase
`timescale 1ns/10ps
module fbo_timer
(
   input  wire logic                     clk_in,
   input  wire logic                     rst_n_in,
   input  wire logic                     load_in,
   input  wire logic [fbo_pkg::CNT_W-1:0] count_in,
   output logic                          done_out
);
   typedef struct packed
   {
      logic [fbo_pkg::CNT_W-1:0] cnt;
   } fbo_tmr_t;

   fbo_tmr_t s_r;
   fbo_tmr_t s_nxt;

   // load on phase entry, then count down to zero
   always_comb
   begin
      s_nxt = s_r;
      if (load_in)
      begin
         s_nxt.cnt = count_in;
      end
      else if (s_r.cnt != '0)
      begin
         s_nxt.cnt = s_r.cnt - 4'h1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // done looks only at the count: the sequencer loads on done, so no path may run back from load
   assign done_out = (s_r.cnt == 4'h1);
endmodule // fbo_timer

// file: dv/fbo_flash_model.sv
// model: behavioural flash device on the far side of the bus-operation controller
`timescale 1ns/10ps
module fbo_flash_model
#(
   parameter logic [7:0] CMD_UNLOCK1 = 8'hAA,
   parameter logic [7:0] CMD_UNLOCK2 = 8'h55,
   parameter logic [7:0] CMD_PROGRAM = 8'hA0,
   parameter logic [7:0] CMD_AUTOSEL = 8'h90,
   parameter logic [7:0] CMD_BYPASS  = 8'h20,
   parameter logic [7:0] CMD_EXIT    = 8'h00,
   parameter logic [7:0] CMD_ERASE   = 8'h6E,
   parameter logic [7:0] CMD_SECTOR  = 8'h3C,
   parameter logic [7:0] CMD_CHIP    = 8'h1E,
   parameter logic [7:0] ID_CODE     = 8'h5A  // arbitrary identification value
)
(
   input  wire logic        chip_select_n_in,
   input  wire logic        output_gate_n_in,
   input  wire logic        write_strobe_n_in,
   input  wire logic        reset_n_in,
   input  wire logic        elevated_voltage_in,
   input  wire logic        width_select_n_in,
   input  wire logic [19:0] addr_in,
   input  wire logic [15:0] dq_in,
   output logic [15:0]      dq_out,
   output logic [15:0]      dq_oe_n_out
);
   // ************************************************************
   // storage, command latches and mode
   // ************************************************************
   logic [15:0] mem [256];
   logic [3:0]  prot;
   logic [2:0]  st;
   logic        busy;
   logic        ers;
   logic        last_d7;
   logic [19:0] lat_a;
   logic [15:0] lat_d;
   logic        lat_lsb;
   logic        lat_word;
   logic        lat_ev;
   logic [15:0] word;
   wire         rst_act;
   wire         rd_act;
   wire         wr_act;

   // reset pin at elevated voltage is not a reset
   assign rst_act = !reset_n_in && !elevated_voltage_in;
   assign rd_act  = !chip_select_n_in && !output_gate_n_in && write_strobe_n_in && !rst_act;
   assign wr_act  = !chip_select_n_in && !write_strobe_n_in && output_gate_n_in && !rst_act;

   // read path: status, id code, word or byte selected by dq15 as lowest address bit
   always_comb
   begin
      word = mem[addr_in[7:0]];
      if (busy)
         dq_out = {8'h00, ~last_d7, 7'h00};
      else if (st == 3'd4)
         dq_out = {8'h00, ID_CODE};
      else if (width_select_n_in)
         dq_out = word;
      else
         dq_out = {8'h00, dq_in[15] ? word[15:8] : word[7:0]};
      dq_oe_n_out = 16'hFFFF;
      if (rd_act)
         dq_oe_n_out = width_select_n_in ? 16'h0000 : 16'hFF00;
   end

   // power-up contents and array-read mode
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = {~i[7:0], i[7:0]};
      st   = 3'd0;
      prot = 4'h0;
      busy = 1'b0;
      ers  = 1'b0;
   end

   // hardware reset aborts and returns to array read
   always @(posedge rst_act)
   begin
      st   = 3'd0;
      busy = 1'b0;
      ers  = 1'b0;
   end

   // status is shown for one read only, then array data again
   always @(posedge output_gate_n_in)
      if (!chip_select_n_in && write_strobe_n_in)
         busy = 1'b0;

   // one write event per select-and-strobe low; sampled 50 ns into the pulse to stay clear of edges
   initial forever
   begin
      @(posedge wr_act);
      #50;
      lat_a    = addr_in;
      lat_d    = dq_in;
      lat_lsb  = dq_in[15];
      lat_word = width_select_n_in;
      lat_ev   = elevated_voltage_in;
      @(negedge wr_act);
      if (rst_act)
         continue;
      if (lat_ev)
      begin
         if (lat_a[1] && !lat_a[0])
            prot[lat_a[19:18]] = !lat_a[6];
      end
      else
         case (st)
            3'd0: st = (lat_d[7:0] == CMD_UNLOCK1) ? 3'd1 : 3'd0;
            3'd1: st = (lat_d[7:0] == CMD_UNLOCK2) ? 3'd2 : 3'd0;
            3'd2:
            begin
               // erase needs a second unlock pair; a sector here is address bits 7..4
               if (ers && !prot[lat_a[19:18]])
                  for (int i = 0; i < 256; i++)
                     if (lat_d[7:0] == CMD_CHIP ||
                         (lat_d[7:0] == CMD_SECTOR && i[7:4] == lat_a[7:4]))
                        mem[i] = 16'hFFFF;
               st = ers ? 3'd0 :
                    (lat_d[7:0] == CMD_PROGRAM) ? 3'd3 :
                    (lat_d[7:0] == CMD_AUTOSEL) ? 3'd4 :
                    (lat_d[7:0] == CMD_BYPASS)  ? 3'd5 : 3'd0;
               ers = !ers && (lat_d[7:0] == CMD_ERASE);
            end
            3'd5: st = (lat_d[7:0] == CMD_PROGRAM) ? 3'd6 :
                       (lat_d[7:0] == CMD_AUTOSEL) ? 3'd7 : 3'd5;
            3'd7: st = (lat_d[7:0] == CMD_EXIT) ? 3'd0 : 3'd5;
            3'd3, 3'd6:
            begin
               if (!prot[lat_a[19:18]])
               begin
                  if (lat_word)
                     mem[lat_a[7:0]] = lat_d;
                  else if (lat_lsb)
                     mem[lat_a[7:0]][15:8] = lat_d[7:0];
                  else
                     mem[lat_a[7:0]][7:0] = lat_d[7:0];
                  busy    = 1'b1;
                  last_d7 = lat_d[7];
               end
               st = (st == 3'd6) ? 3'd5 : 3'd0;
            end
            default: ;
         endcase
   end
endmodule // fbo_flash_model

// file: dv/tb_flash_bus_operation_decode.sv
// testbench: host controller driving the behavioural flash through its bus operations
`timescale 1ns/10ps
module tb_flash_bus_operation_decode;
   localparam logic [19:0] UNL_A1 = 20'h0_0555;
   localparam logic [19:0] UNL_A2 = 20'h0_02AA;
   logic                clk_in;
   logic                rst_n_in;
   logic                req_valid_in;
   fbo_pkg::fbo_req_t   req_in;
   logic                req_ready_out;
   logic                rdata_valid_out;
   logic [15:0]         rdata_out;
   logic [15:0]         dq_wire;
   logic [15:0]         flt;
   logic                chip_select_n_out;
   logic                output_gate_n_out;
   logic                write_strobe_n_out;
   logic                reset_n_out;
   logic                elevated_voltage_out;
   logic                width_select_n_out;
   logic [19:0]         addr_out;
   logic [15:0]         dq_out;
   logic [15:0]         dq_oe_n_out;
   logic [15:0]         mdl_dq;
   logic [15:0]         mdl_oe_n;
   int                  mismatches;
   int                  checks_done;
   int                  cycles;

   // ************************************************************
   // design, device model and the shared data wire
   // ************************************************************
   fbo_ctrl uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
      .req_in(req_in), .req_ready_out(req_ready_out), .rdata_valid_out(rdata_valid_out),
      .rdata_out(rdata_out), .dq_in(dq_wire), .chip_select_n_out(chip_select_n_out),
      .output_gate_n_out(output_gate_n_out), .write_strobe_n_out(write_strobe_n_out),
      .reset_n_out(reset_n_out), .elevated_voltage_out(elevated_voltage_out),
      .width_select_n_out(width_select_n_out), .addr_out(addr_out), .dq_out(dq_out),
      .dq_oe_n_out(dq_oe_n_out));
   fbo_flash_model mdl (.chip_select_n_in(chip_select_n_out),
      .output_gate_n_in(output_gate_n_out), .write_strobe_n_in(write_strobe_n_out),
      .reset_n_in(reset_n_out), .elevated_voltage_in(elevated_voltage_out),
      .width_select_n_in(width_select_n_out), .addr_in(addr_out), .dq_in(dq_wire),
      .dq_out(mdl_dq), .dq_oe_n_out(mdl_oe_n));

   // undriven bits toggle every cycle so a stale value never reads as good data
   assign dq_wire = (~dq_oe_n_out & dq_out) | (dq_oe_n_out & ~mdl_oe_n & mdl_dq)
                  | (dq_oe_n_out & mdl_oe_n & flt);

   always #50 clk_in = ~clk_in;

   // clock count for the hang limit, and the floating pattern
   always @(posedge clk_in)
   begin
      flt    <= ~flt;
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         mismatches++;
         print_verdict();
      end
   end

   // ************************************************************
   // compare, transfer and command tasks
   // ************************************************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic xfer(input fbo_pkg::fbo_op_t op, input logic bm, input logic [19:0] a,
                       input logic lsb, input logic [15:0] wd, output logic [15:0] rd);
      rd = 16'hFFFF;
      req_in <= '{op: op, byte_mode: bm, addr: a, addr_lsb: lsb, wdata: wd};
      req_valid_in <= 1'b1;
      do @(negedge clk_in); while (req_ready_out !== 1'b1);
      @(posedge clk_in);
      req_valid_in <= 1'b0;
      do
      begin
         @(negedge clk_in);
         if (rdata_valid_out === 1'b1)
            rd = rdata_out;
      end
      while (req_ready_out !== 1'b1);
      @(posedge clk_in);
   endtask

   task automatic wr(input logic bm, input logic [19:0] a, input logic [7:0] d);
      logic [15:0] rd;
      xfer(fbo_pkg::FBO_OP_WRITE, bm, a, 1'b0, {8'h00, d}, rd);
   endtask

   task automatic rd_chk(input logic bm, input logic [19:0] a, input logic lsb,
                         input logic [15:0] exp);
      logic [15:0] rd;
      xfer(fbo_pkg::FBO_OP_READ, bm, a, lsb, 16'h0000, rd);
      check(rd, exp);
   endtask

   // unlock pair then the command byte
   task automatic cmd(input logic bm, input logic [7:0] c);
      wr(bm, UNL_A1, mdl.CMD_UNLOCK1);
      wr(bm, UNL_A2, mdl.CMD_UNLOCK2);
      wr(bm, UNL_A1, c);
   endtask

   // program, then the first read must show status with bit 7 inverted
   task automatic prog(input logic bm, input logic [19:0] a, input logic lsb,
                       input logic [15:0] d, input logic byp);
      logic [15:0] rd;
      if (byp)
         wr(bm, UNL_A1, mdl.CMD_PROGRAM);
      else
         cmd(bm, mdl.CMD_PROGRAM);
      xfer(fbo_pkg::FBO_OP_WRITE, bm, a, lsb, d, rd);
      rd_chk(bm, a, lsb, {8'h00, ~d[7], 7'h00});
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // host and device never drive the same bit at once
   always @(negedge clk_in)
      if (rst_n_in)
         check(~dq_oe_n_out & ~mdl_oe_n, 16'h0000);

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      logic [15:0] rd;
      clk_in       = 1'b0;
      rst_n_in     = 1'b0;
      req_valid_in = 1'b0;
      req_in       = '0;
      flt          = 16'hA5A5;
      mismatches   = 0;
      checks_done  = 0;
      cycles       = 0;
      repeat (4) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      rd_chk(1'b0, 20'h0_0010, 1'b0, 16'hEF10);
      prog(1'b0, 20'h0_0020, 1'b0, 16'h1234, 1'b0);
      rd_chk(1'b0, 20'h0_0020, 1'b0, 16'h1234);
      prog(1'b1, 20'h0_0021, 1'b1, 16'h00AB, 1'b0);
      rd_chk(1'b0, 20'h0_0021, 1'b0, 16'hAB21);
      rd_chk(1'b1, 20'h0_0021, 1'b0, 16'h0021);
      rd_chk(1'b1, 20'h0_0021, 1'b1, 16'h00AB);
      // bypass: two writes per word, then leave it
      cmd(1'b0, mdl.CMD_BYPASS);
      prog(1'b0, 20'h0_0030, 1'b0, 16'h5678, 1'b1);
      prog(1'b0, 20'h0_0031, 1'b0, 16'h9A80, 1'b1);
      rd_chk(1'b0, 20'h0_0030, 1'b0, 16'h5678);
      rd_chk(1'b0, 20'h0_0031, 1'b0, 16'h9A80);
      wr(1'b0, UNL_A1, mdl.CMD_AUTOSEL);
      wr(1'b0, UNL_A1, mdl.CMD_EXIT);
      rd_chk(1'b0, 20'h0_0032, 1'b0, 16'hCD32);
      // identification mode, left only by the hardware reset operation
      cmd(1'b0, mdl.CMD_AUTOSEL);
      rd_chk(1'b0, 20'h0_0044, 1'b0, {8'h00, mdl.ID_CODE});
      xfer(fbo_pkg::FBO_OP_RESET, 1'b0, 20'h0_0000, 1'b0, 16'h0000, rd);
      rd_chk(1'b0, 20'h0_0044, 1'b0, 16'hBB44);
      // protected sector refuses programming until unprotected
      xfer(fbo_pkg::FBO_OP_PROTECT, 1'b0, 20'h4_0000, 1'b0, 16'h0000, rd);
      cmd(1'b0, mdl.CMD_PROGRAM);
      xfer(fbo_pkg::FBO_OP_WRITE, 1'b0, 20'h4_0005, 1'b0, 16'hBEEF, rd);
      rd_chk(1'b0, 20'h4_0005, 1'b0, 16'hFA05);
      xfer(fbo_pkg::FBO_OP_UNPROTECT, 1'b0, 20'h4_0000, 1'b0, 16'h0000, rd);
      prog(1'b0, 20'h4_0005, 1'b0, 16'hBEEF, 1'b0);
      rd_chk(1'b0, 20'h4_0005, 1'b0, 16'hBEEF);
      // sector erase clears one block only, chip erase clears the rest
      cmd(1'b0, mdl.CMD_ERASE);
      wr(1'b0, UNL_A1, mdl.CMD_UNLOCK1);
      wr(1'b0, UNL_A2, mdl.CMD_UNLOCK2);
      wr(1'b0, 20'h0_0050, mdl.CMD_SECTOR);
      rd_chk(1'b0, 20'h0_0055, 1'b0, 16'hFFFF);
      rd_chk(1'b0, 20'h0_0065, 1'b0, 16'h9A65);
      cmd(1'b0, mdl.CMD_ERASE);
      cmd(1'b0, mdl.CMD_CHIP);
      rd_chk(1'b0, 20'h0_0020, 1'b0, 16'hFFFF);
      print_verdict();
   end
endmodule // tb_flash_bus_operation_decode
